// >>> asp_consts.vh
// Constants for the two-instance asynchronous serial port
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define ASP_P1_MODE    10'h20c
`define ASP_P1_STAT    10'h20e
`define ASP_P1_TXD     10'h210
`define ASP_P1_RXD     10'h212
`define ASP_P1_BAUD    10'h214
`define ASP_P2_MODE    10'h216
`define ASP_P2_STAT    10'h218
`define ASP_P2_TXD     10'h21a
`define ASP_P2_RXD     10'h21c
`define ASP_P2_BAUD    10'h21e
// Local register selectors inside a port
`define ASP_SEL_MODE   3'h0
`define ASP_SEL_STAT   3'h1
`define ASP_SEL_TXD    3'h2
`define ASP_SEL_RXD    3'h3
`define ASP_SEL_BAUD   3'h4
// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define ASP_M_EN       15
`define ASP_M_ISTOP    13
`define ASP_M_WAKE     7
`define ASP_M_LOOP     6
`define ASP_M_PDS_HI   2
`define ASP_M_PDS_LO   1
`define ASP_M_STOP2    0
`define ASP_MODE_MASK1 16'ha4e7
`define ASP_MODE_MASK2 16'ha0e7
// ----------------------------------------------------------------
// Status register fields and reset value
// ----------------------------------------------------------------
`define ASP_S_TXISEL   15
`define ASP_S_BRK      11
`define ASP_S_TXEN     10
`define ASP_S_RXIS_HI  7
`define ASP_S_RXIS_LO  6
`define ASP_S_ADDRESS_DETECT_ENABLE    5
`define ASP_S_OVERRUN_ERROR_FLAG     1
`define ASP_STAT_RST   16'h0110
`define ASP_BAUD_RST   16'h0000
// ----------------------------------------------------------------
// Bit timing: sixteen ticks per bit, sample at mid start bit
// ----------------------------------------------------------------
`define ASP_TICK_MID   4'h7
`define ASP_TICK_LAST  4'hf
`define ASP_RXIS_THREE 2'h2
`define ASP_RXIS_FULL  2'h3
`define ASP_PDS_NINE   2'h3
`define ASP_FIFO_THREE 3'h3
`define ASP_FIFO_FULL  3'h4
`endif

// >>> asp_serial_port.v
// Two asynchronous serial ports with APB registers and power-mode handling
//
// Notes on behaviour
// - In Sleep the port's clocking stops; logic is held still.
// - Sleep during transmit aborts the character; output line goes high unless break is set.
// - Sleep during receive aborts the character unfinished.
// - Sleep leaves every register, buffer and divisor untouched.
// - With wake bit set, a falling receive edge in Sleep raises receive interrupt.
// - The receive interrupt select field does not affect that wake interrupt.
// - The wake interrupt, if enabled outside, brings the chip out of Sleep.
// - Wake interrupt only while the port enable bit is set.
// - In Idle the port runs if idle-stop is 0, halts if 1.
// - Status low byte: rx select(2), addr detect, rx idle, parity_error_flag, framing_error_flag, overrun_error_flag, rx avail.
// - Unimplemented register bits read as zero.
// - Baud divisor is a full 16-bit register reset to zero.
// - First port registers sit at indices 020C through 0214.
// - Second port registers at 0216 through 021E, without alternate pin bit.
// - Bit rate is clock over sixteen times divisor plus one.
// - Rx interrupt per character for 00/01, at 3 held for 10, at 4 for 11.
// - Break bit forces the output line low over everything else.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "asp_consts.vh"

module asp_port #(
   parameter [15:0] MODE_MASK = `ASP_MODE_MASK1
) (
   input  wire        clock,
   input  wire        rstN,
   input  wire        sleepMode,
   input  wire        idleMode,
   input  wire        rxPin,
   input  wire        regWr,
   input  wire        regRd,
   input  wire [2:0]  regSel,
   input  wire [15:0] wdata,
   output reg  [15:0] rdata,
   output reg         txPin_q,
   output reg         rxIrq_q,
   output reg         txIrq_q
);
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_START = 3'h1;
   localparam [2:0] S_DATA  = 3'h2;
   localparam [2:0] S_PAR   = 3'h3;
   localparam [2:0] S_STOP  = 3'h4;
   localparam [15:0] STAT_RST = `ASP_STAT_RST;

   function parityOf;
      input [7:0] d;
      input       odd;
      begin
         parityOf = (^d) ^ odd;
      end
   endfunction

   reg  [15:0] mode_q;
   reg  [15:0] baud_q;
   reg  [15:0] baudCnt_q;
   reg         txIsel_q;
   reg         brk_q;
   reg         txEn_q;
   reg  [1:0]  rxIsel_q;
   reg         addrEn_q;
   reg         overrun_error_flag_q;
   reg  [8:0]  txBuf_q;
   reg         txFull_q;
   reg  [8:0]  txSh_q;
   reg         txPar_q;
   reg  [2:0]  tState_q;
   reg  [3:0]  tBit_q;
   reg  [3:0]  tTick_q;
   reg  [8:0]  rSh_q;
   reg  [2:0]  rState_q;
   reg  [3:0]  rBit_q;
   reg  [3:0]  rTick_q;
   reg         rPerr_q;
   reg         rFerr_q;
   reg         rxPrev_q;
   reg         pinPrev_q;
   reg  [10:0] fifo [0:3];
   reg  [1:0]  wrPtr_q;
   reg  [1:0]  rdPtr_q;
   reg  [2:0]  fCnt_q;
   integer     k;

   wire        enable   = mode_q[`ASP_M_EN];
   wire [1:0]  pds      = mode_q[`ASP_M_PDS_HI:`ASP_M_PDS_LO];
   wire        nine     = (pds == `ASP_PDS_NINE);
   wire        parOn    = (pds != 2'h0) && !nine;
   wire [3:0]  nBits    = nine ? 4'h9 : 4'h8;
   // ----------------------------------------------------------------
   // Power gating of the port's activity
   // ----------------------------------------------------------------
   wire        abort    = sleepMode || !enable;
   wire        run      = !abort && !(idleMode && mode_q[`ASP_M_ISTOP]);
   wire        tick     = run && (baudCnt_q == baud_q);
   wire        rxSrc    = mode_q[`ASP_M_LOOP] ? txPin_q : rxPin;
   wire        fEmpty   = (fCnt_q == 3'h0);
   wire [10:0] fTop     = fifo[rdPtr_q];
   wire        pop      = regRd && (regSel == `ASP_SEL_RXD) && !fEmpty;
   wire        wrStat   = regWr && (regSel == `ASP_SEL_STAT);
   wire        wrTx     = regWr && (regSel == `ASP_SEL_TXD);
   wire        tx_shift_empty     = (tState_q == S_IDLE);
   wire        receiver_idle_flag    = (rState_q == S_IDLE);
   wire        load     = run && tx_shift_empty && txFull_q && txEn_q;
   wire        rEnd     = tick && (rTick_q == `ASP_TICK_LAST);
   wire        tEnd     = tick && (tTick_q == `ASP_TICK_LAST);
   wire        lastStop = (rState_q == S_STOP) && (!mode_q[`ASP_M_STOP2] || rBit_q != 4'h0);
   wire        rDone    = rEnd && lastStop;
   wire [8:0]  rData    = nine ? rSh_q : {1'b0, rSh_q[8:1]};
   wire        rFerrNow = rFerr_q || !rxSrc;
   wire        keep     = !(addrEn_q && nine) || rData[8];
   wire        push     = rDone && keep && (fCnt_q != `ASP_FIFO_FULL);
   wire [2:0]  newCnt   = fCnt_q + 3'h1;
   wire        wakeEdge = sleepMode && enable && mode_q[`ASP_M_WAKE] &&
                          pinPrev_q && !rxPin;
   reg         txBit;
   reg         rxIrqD;

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   always @* begin
      case (regSel)
         `ASP_SEL_MODE: rdata = mode_q;
         `ASP_SEL_STAT: rdata = {txIsel_q, 3'h0, brk_q, txEn_q, txFull_q, tx_shift_empty,
                                 rxIsel_q, addrEn_q, receiver_idle_flag, fTop[10], fTop[9],
                                 overrun_error_flag_q, !fEmpty};
         `ASP_SEL_RXD:  rdata = {7'h00, fTop[8:0]};
         `ASP_SEL_BAUD: rdata = baud_q;
         default:       rdata = 16'h0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Transmit line level
   // ----------------------------------------------------------------
   always @* begin
      case (tState_q)
         S_START: txBit = 1'b0;
         S_DATA:  txBit = txSh_q[0];
         S_PAR:   txBit = txPar_q;
         default: txBit = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // Receive interrupt condition
   // ----------------------------------------------------------------
   always @* begin
      rxIrqD = wakeEdge;
      if (push) begin
         if (addrEn_q && nine)
            rxIrqD = 1'b1;
         else if (rxIsel_q == `ASP_RXIS_THREE)
            rxIrqD = (newCnt == `ASP_FIFO_THREE);
         else if (rxIsel_q == `ASP_RXIS_FULL)
            rxIrqD = (newCnt == `ASP_FIFO_FULL);
         else
            rxIrqD = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Control registers and baud divider
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         mode_q    <= 16'h0000;
         baud_q    <= `ASP_BAUD_RST;
         baudCnt_q <= 16'h0000;
         txIsel_q  <= STAT_RST[`ASP_S_TXISEL];
         brk_q     <= STAT_RST[`ASP_S_BRK];
         txEn_q    <= STAT_RST[`ASP_S_TXEN];
         rxIsel_q  <= STAT_RST[`ASP_S_RXIS_HI:`ASP_S_RXIS_LO];
         addrEn_q  <= STAT_RST[`ASP_S_ADDRESS_DETECT_ENABLE];
         overrun_error_flag_q    <= STAT_RST[`ASP_S_OVERRUN_ERROR_FLAG];
         txBuf_q   <= 9'h000;
         txFull_q  <= 1'b0;
         pinPrev_q <= 1'b1;
      end else begin
         pinPrev_q <= rxPin;
         if (regWr && regSel == `ASP_SEL_MODE)
            mode_q <= wdata & MODE_MASK;
         if (regWr && regSel == `ASP_SEL_BAUD)
            baud_q <= wdata;
         if (abort)
            baudCnt_q <= 16'h0000;
         else if (run)
            baudCnt_q <= tick ? 16'h0000 : baudCnt_q + 16'h0001;
         if (wrStat) begin
            txIsel_q <= wdata[`ASP_S_TXISEL];
            brk_q    <= wdata[`ASP_S_BRK];
            txEn_q   <= wdata[`ASP_S_TXEN];
            rxIsel_q <= wdata[`ASP_S_RXIS_HI:`ASP_S_RXIS_LO];
            addrEn_q <= wdata[`ASP_S_ADDRESS_DETECT_ENABLE];
         end
         // Overrun sets over a same-cycle software clear
         if (rDone && keep && fCnt_q == `ASP_FIFO_FULL)
            overrun_error_flag_q <= 1'b1;
         else if (wrStat && !wdata[`ASP_S_OVERRUN_ERROR_FLAG])
            overrun_error_flag_q <= 1'b0;
         if (wrTx && !txFull_q) begin
            txBuf_q  <= wdata[8:0];
            txFull_q <= 1'b1;
         end else if (load)
            txFull_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         tState_q <= S_IDLE;
         tBit_q   <= 4'h0;
         tTick_q  <= 4'h0;
         txSh_q   <= 9'h000;
         txPar_q  <= 1'b0;
         txPin_q  <= 1'b1;
         txIrq_q  <= 1'b0;
      end else begin
         txIrq_q <= load && (!txIsel_q || !(wrTx && !txFull_q));
         txPin_q <= brk_q ? 1'b0 : (abort ? 1'b1 : txBit);
         if (abort) begin
            tState_q <= S_IDLE;
            tTick_q  <= 4'h0;
         end else if (load) begin
            txSh_q   <= txBuf_q;
            txPar_q  <= parityOf(txBuf_q[7:0], pds[1]);
            tState_q <= S_START;
            tTick_q  <= 4'h0;
            tBit_q   <= 4'h0;
         end else if (tick) begin
            tTick_q <= tTick_q + 4'h1;
            if (tEnd) begin
               case (tState_q)
                  S_START: tState_q <= S_DATA;
                  S_DATA: begin
                     txSh_q <= {1'b0, txSh_q[8:1]};
                     tBit_q <= tBit_q + 4'h1;
                     if (tBit_q == nBits - 4'h1) begin
                        tBit_q   <= 4'h0;
                        tState_q <= parOn ? S_PAR : S_STOP;
                     end
                  end
                  S_PAR: tState_q <= S_STOP;
                  S_STOP: begin
                     tBit_q <= 4'h1;
                     if (!mode_q[`ASP_M_STOP2] || tBit_q != 4'h0)
                        tState_q <= S_IDLE;
                  end
                  default: tState_q <= S_IDLE;
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Receiver; registers and buffer are not touched by an abort
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         rState_q <= S_IDLE;
         rBit_q   <= 4'h0;
         rTick_q  <= 4'h0;
         rSh_q    <= 9'h000;
         rPerr_q  <= 1'b0;
         rFerr_q  <= 1'b0;
         rxPrev_q <= 1'b1;
         rxIrq_q  <= 1'b0;
      end else begin
         rxIrq_q <= rxIrqD;
         if (run)
            rxPrev_q <= rxSrc;
         if (abort) begin
            rState_q <= S_IDLE;
            rTick_q  <= 4'h0;
         end else if (run) begin
            case (rState_q)
               S_IDLE: begin
                  // Waits for high line first, so a break is not a start
                  if (!overrun_error_flag_q && rxPrev_q && !rxSrc) begin
                     rState_q <= S_START;
                     rTick_q  <= 4'h0;
                     rBit_q   <= 4'h0;
                     rPerr_q  <= 1'b0;
                     rFerr_q  <= 1'b0;
                  end
               end
               S_START: begin
                  if (tick) begin
                     rTick_q <= rTick_q + 4'h1;
                     if (rTick_q == `ASP_TICK_MID) begin
                        rTick_q  <= 4'h0;
                        rState_q <= rxSrc ? S_IDLE : S_DATA;
                     end
                  end
               end
               default: begin
                  if (tick)
                     rTick_q <= rTick_q + 4'h1;
                  if (rEnd) begin
                     rTick_q <= 4'h0;
                     case (rState_q)
                        S_DATA: begin
                           rSh_q  <= {rxSrc, rSh_q[8:1]};
                           rBit_q <= rBit_q + 4'h1;
                           if (rBit_q == nBits - 4'h1) begin
                              rBit_q   <= 4'h0;
                              rState_q <= parOn ? S_PAR : S_STOP;
                           end
                        end
                        S_PAR: begin
                           rPerr_q  <= rxSrc != parityOf(rSh_q[8:1], pds[1]);
                           rState_q <= S_STOP;
                        end
                        S_STOP: begin
                           rFerr_q <= rFerrNow;
                           rBit_q  <= 4'h1;
                           if (lastStop)
                              rState_q <= S_IDLE;
                        end
                        default: rState_q <= S_IDLE;
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Four-word receive buffer with per-word error flags
   // ----------------------------------------------------------------
   // Buffer words are cleared so that an empty read after reset shows zero
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         wrPtr_q <= 2'h0;
         rdPtr_q <= 2'h0;
         fCnt_q  <= 3'h0;
         for (k = 0; k < `ASP_FIFO_FULL; k = k + 1)
            fifo[k] <= 11'h000;
      end else begin
         if (push)
            fifo[wrPtr_q] <= {rPerr_q, rFerrNow, rData};
         if (push)
            wrPtr_q <= wrPtr_q + 2'h1;
         if (pop)
            rdPtr_q <= rdPtr_q + 2'h1;
         if (push && !pop)
            fCnt_q <= newCnt;
         else if (pop && !push)
            fCnt_q <= fCnt_q - 3'h1;
      end
   end
endmodule // asp_port

module asp_serial_port (
   input  wire        clock,
   input  wire        nrst,
   input  wire        sleepMode,
   input  wire        idleMode,
   input  wire [11:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_q,
   output reg         pready_q,
   output reg         pslverr_q,
   input  wire [1:0]  serialInPin,
   output wire [1:0]  serialOutPin,
   output wire [1:0]  rxIrq,
   output wire [1:0]  txIrq
);
   reg  [1:0]  rstSync_q;
   reg  [1:0]  rxMeta_q;
   reg  [1:0]  rxSync_q;
   reg         hit;
   reg         port;
   reg  [2:0]  sel;
   wire        rstN = rstSync_q[1];
   wire [15:0] rd1;
   wire [15:0] rd2;
   wire        access = psel && penable && pready_q && hit;
   wire        wr1 = access && pwrite && !port;
   wire        wr2 = access && pwrite && port;
   wire        rdA1 = access && !pwrite && !port;
   wire        rdA2 = access && !pwrite && port;

   // ----------------------------------------------------------------
   // Address decode: byte address is four times the index
   // ----------------------------------------------------------------
   always @* begin
      hit  = (paddr[1:0] == 2'h0);
      port = 1'b0;
      sel  = `ASP_SEL_MODE;
      case (paddr[11:2])
         `ASP_P1_MODE: sel = `ASP_SEL_MODE;
         `ASP_P1_STAT: sel = `ASP_SEL_STAT;
         `ASP_P1_TXD:  sel = `ASP_SEL_TXD;
         `ASP_P1_RXD:  sel = `ASP_SEL_RXD;
         `ASP_P1_BAUD: sel = `ASP_SEL_BAUD;
         `ASP_P2_MODE: begin port = 1'b1; sel = `ASP_SEL_MODE; end
         `ASP_P2_STAT: begin port = 1'b1; sel = `ASP_SEL_STAT; end
         `ASP_P2_TXD:  begin port = 1'b1; sel = `ASP_SEL_TXD;  end
         `ASP_P2_RXD:  begin port = 1'b1; sel = `ASP_SEL_RXD;  end
         `ASP_P2_BAUD: begin port = 1'b1; sel = `ASP_SEL_BAUD; end
         default:      hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rstSync_q <= 2'h0;
         rxMeta_q  <= 2'h3;
         rxSync_q  <= 2'h3;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
         rxMeta_q  <= serialInPin;
         rxSync_q  <= rxMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // APB slave: one wait-free access phase after setup
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         pready_q  <= 1'b1;
         pslverr_q <= !hit;
         prdata_q  <= {16'h0000, hit ? (port ? rd2 : rd1) : 16'h0000};
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   asp_port #(.MODE_MASK(`ASP_MODE_MASK1)) u_port1 (
      .clock     (clock),
      .rstN      (rstN),
      .sleepMode (sleepMode),
      .idleMode  (idleMode),
      .rxPin     (rxSync_q[0]),
      .regWr     (wr1),
      .regRd     (rdA1),
      .regSel    (sel),
      .wdata     (pwdata[15:0]),
      .rdata     (rd1),
      .txPin_q   (serialOutPin[0]),
      .rxIrq_q   (rxIrq[0]),
      .txIrq_q   (txIrq[0])
   );

   asp_port #(.MODE_MASK(`ASP_MODE_MASK2)) u_port2 (
      .clock     (clock),
      .rstN      (rstN),
      .sleepMode (sleepMode),
      .idleMode  (idleMode),
      .rxPin     (rxSync_q[1]),
      .regWr     (wr2),
      .regRd     (rdA2),
      .regSel    (sel),
      .wdata     (pwdata[15:0]),
      .rdata     (rd2),
      .txPin_q   (serialOutPin[1]),
      .rxIrq_q   (rxIrq[1]),
      .txIrq_q   (txIrq[1])
   );
endmodule // asp_serial_port

// >>> asp_remote_peer.sv
// Remote serial transmitter model driving one receive line
`timescale 1ns/1ps
module asp_remote_peer #(
   parameter BIT_CLOCKS = 32
) (
   input  wire       clock,
   input  wire       send,
   input  wire [7:0] data,
   output reg        line
);
   wire [9:0] frame = {1'b1, data, 1'b0};
   integer    i;
   initial line = 1'b1;
   // Start, data LSB first, one stop, idle high
   always @(posedge send) begin
      for (i = 0; i < 10; i = i + 1) begin
         line <= frame[i];
         repeat (BIT_CLOCKS) @(posedge clock);
      end
   end
endmodule // asp_remote_peer

// >>> asp_serial_port_sva.sv
// Checker for bus answers and line behaviour of the serial block
`timescale 1ns/1ps
module asp_serial_port_sva (
   input wire        clock,
   input wire        nrst,
   input wire        sleepMode,
   input wire [11:0] paddr,
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata_q,
   input wire        pready_q,
   input wire        pslverr_q,
   input wire [1:0]  serialOutPin,
   input wire [1:0]  rxIrq,
   input wire [1:0]  txIrq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_ready_after_setup: assert property (psel && !penable |=> pready_q)
      else $error("no ready after setup");
   a_ready_in_access: assert property (pready_q |-> psel && penable)
      else $error("ready outside access");
   a_ready_one_cycle: assert property (pready_q |=> !pready_q)
      else $error("ready held too long");
   a_misalign_error: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr_q)
      else $error("misaligned access accepted");
   a_error_data_zero: assert property (pslverr_q |-> prdata_q == 32'h0)
      else $error("error read not zero");
   a_upper_half_zero: assert property (pready_q |-> prdata_q[31:16] == 16'h0)
      else $error("upper read bits set");
   a_sleep_line_high: assert property (sleepMode [*2] |-> serialOutPin == 2'h3)
      else $error("line not high in sleep");
   a_sleep_tx_quiet: assert property (sleepMode [*2] |-> txIrq == 2'h0)
      else $error("tx event in sleep");
   c_sleep_wake: cover property (sleepMode && rxIrq[0]);
   c_misalign: cover property (pready_q && pslverr_q);
   c_tx_start: cover property ($fell(serialOutPin[0]));
   c_read_done: cover property (pready_q && !pslverr_q);
endmodule // asp_serial_port_sva
bind asp_serial_port asp_serial_port_sva u_sva (.clock(clock), .nrst(nrst),
   .sleepMode(sleepMode), .paddr(paddr), .psel(psel), .penable(penable),
   .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
   .serialOutPin(serialOutPin), .rxIrq(rxIrq), .txIrq(txIrq));

// >>> tb_top.sv
// Testbench for the two-port serial block
`timescale 1ns/1ps
`include "asp_consts.vh"
module tb_top;
   reg         clock = 1'b0;
   reg         nrst = 1'b0;
   reg         sleepMode = 1'b0;
   reg         idleMode = 1'b0;
   reg  [11:0] paddr = 12'h0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [31:0] pwdata = 32'h0;
   reg         send = 1'b0;
   reg  [7:0]  sendData = 8'h0;
   reg  [31:0] rd = 32'h0;
   reg         errSeen = 1'b0;
   wire        peerLine;
   wire [31:0] prdata_q;
   wire        pready_q;
   wire        pslverr_q;
   wire [1:0]  serialOutPin;
   wire [1:0]  rxIrq;
   wire [1:0]  txIrq;
   integer     bad_count = 0;
   integer     tests_run = 0;
   integer     irqCount = 0;
   integer     lowCount = 0;
   integer     txCount = 0;
   integer     i, b, n0;
   always #4 clock = ~clock;
   asp_serial_port dut (.clock(clock), .nrst(nrst), .sleepMode(sleepMode),
      .idleMode(idleMode), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .serialInPin({1'b1, peerLine}), .serialOutPin(serialOutPin), .rxIrq(rxIrq),
      .txIrq(txIrq));
   asp_remote_peer #(.BIT_CLOCKS(32)) peer (.clock(clock), .send(send), .data(sendData),
      .line(peerLine));
   always @(posedge clock) begin
      if (rxIrq[0] === 1'b1) irqCount <= irqCount + 1;
      if (serialOutPin[0] === 1'b0) lowCount <= lowCount + 1;
      if (txIrq[0] === 1'b1) txCount <= txCount + 1;
   end
   function [11:0] ad(input integer idx);
      ad = {idx[9:0], 2'b00};
   endfunction
   task check(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         paddr <= a;
         pwrite <= wr;
         pwdata <= d;
         psel <= 1'b1;
         @(posedge clock);
         penable <= 1'b1;
         @(posedge clock);
         while (pready_q !== 1'b1)
            @(posedge clock);
         rd = prdata_q;
         errSeen = pslverr_q;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clock);
      end
   endtask
   task rdc(input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         check(rd, exp);
      end
   endtask
   task sendChar(input [7:0] d);
      begin
         sendData <= d;
         send <= 1'b1;
         @(posedge clock);
         send <= 1'b0;
         repeat (360) @(posedge clock);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", tests_run, bad_count);
         if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      #160000;
      bad_count = bad_count + 1;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      for (i = 0; i < 2; i = i + 1) begin
         b = `ASP_P1_MODE + i * 10;
         rdc(ad(b), 32'h0);
         rdc(ad(b + 2), 32'h0110);
         rdc(ad(b + 6), 32'h0);
         rdc(ad(b + 8), 32'h0);
         apb(1'b1, ad(b + 8), 32'hffffffff);
         rdc(ad(b + 8), 32'hffff);
         apb(1'b1, ad(b), 32'hffff7fff);
         rdc(ad(b), (i == 0) ? 32'h24e7 : 32'h20e7);
         apb(1'b1, ad(b), 32'h0);
      end
      apb(1'b0, 12'h880, 32'h0);
      check(errSeen, 1'b1);
      apb(1'b0, 12'h831, 32'h0);
      check(errSeen, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, ad(`ASP_P1_BAUD), 32'h1);
      apb(1'b1, ad(`ASP_P1_MODE), 32'h8000);
      sendChar(8'ha5);
      rdc(ad(`ASP_P1_RXD), 32'h00a5);
      apb(1'b1, ad(`ASP_P1_STAT), 32'h0080);
      n0 = irqCount;
      for (i = 0; i < 3; i = i + 1) sendChar(8'h30 + i);
      check(irqCount - n0, 1);
      rdc(ad(`ASP_P1_STAT), 32'h0191);
      for (i = 0; i < 3; i = i + 1) rdc(ad(`ASP_P1_RXD), 32'h30 + i);
      apb(1'b1, ad(`ASP_P1_STAT), 32'h00c0);
      apb(1'b1, ad(`ASP_P1_MODE), 32'h8080);
      n0 = irqCount;
      sleepMode <= 1'b1;
      sendChar(8'hff);
      sleepMode <= 1'b0;
      check(irqCount - n0, 1);
      rdc(ad(`ASP_P1_STAT), 32'h01d0);
      rdc(ad(`ASP_P1_MODE), 32'h8080);
      rdc(ad(`ASP_P1_BAUD), 32'h1);
      apb(1'b1, ad(`ASP_P1_MODE), 32'h0080);
      n0 = irqCount;
      sleepMode <= 1'b1;
      sendChar(8'hff);
      sleepMode <= 1'b0;
      check(irqCount - n0, 0);
      apb(1'b1, ad(`ASP_P1_MODE), 32'ha000);
      idleMode <= 1'b1;
      n0 = lowCount;
      apb(1'b1, ad(`ASP_P1_STAT), 32'h0400);
      apb(1'b1, ad(`ASP_P1_TXD), 32'h0055);
      repeat (200) @(posedge clock);
      check(lowCount - n0, 0);
      check(txCount, 0);
      apb(1'b1, ad(`ASP_P1_MODE), 32'h8000);
      repeat (40) @(posedge clock);
      check(lowCount > n0, 1'b1);
      check(txCount, 1);
      sleepMode <= 1'b1;
      repeat (3) @(posedge clock);
      check(serialOutPin, 2'h3);
      sleepMode <= 1'b0;
      idleMode <= 1'b0;
      apb(1'b1, ad(`ASP_P1_STAT), 32'h0c00);
      repeat (3) @(posedge clock);
      check(serialOutPin, 2'h2);
      tally_and_finish;
   end
endmodule // tb_top
